/* File: spu_byte_clamp.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spu_params.svh"
module spu_byte_clamp (
  input  wire logic [15:0] half_i,
  output logic      [7:0]  byte_o
);
  // Signed halfword to unsigned byte
  always_comb begin
    if (half_i[15]) begin
      byte_o = `SPU_BYTE_MIN;                  // [RULE7]
    end else if (half_i[14:8] != 7'h00) begin
      byte_o = `SPU_BYTE_MAX;                  // [RULE6]
    end else begin
      byte_o = half_i[7:0];                    // [RULE5]
    end
  end
endmodule
`default_nettype wire

/* File: spu_pack_unit.sv */
`timescale 1ns/1ns
`default_nettype none
`include "spu_params.svh"
module spu_pack_unit
  import spu_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        CE_I,
  input  wire logic        S_VALID_I,
  input  wire logic        S_UNIT_I,
  input  wire logic [3:0]  S_OPFIELD_I,
  input  wire logic        S_COND_I,
  input  wire logic [4:0]  S_DST_I,
  input  wire logic [31:0] FIRST_OPERAND_I,
  input  wire logic [31:0] SECOND_OPERAND_I,
  input  wire logic        S_CROSS_I,
  input  wire logic        M_VALID_I,
  input  wire logic        M_UNIT_I,
  input  wire logic [4:0]  M_OPFIELD_I,
  input  wire logic        M_COND_I,
  output logic             S_WE_O,
  output logic             S_UNIT_O,
  output logic [4:0]       S_DST_O,
  output logic [31:0]      S_RESULT_O,
  output logic             S_CROSS_O,
  output logic             SAT_SET_O,
  output logic             SHIFT_DEC_O,
  output logic             SHIFT_UNIT_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  spu_op_t op;
  logic    do_write;

  // Select operation from the S opfield; other codes belong to other units
  always_comb begin
    unique case (S_OPFIELD_I)
      `SPU_OP_S_HALF_PACK: begin
        op = SPU_HALF_PACK;
      end
      `SPU_OP_S_BYTE_PACK: begin
        op = SPU_BYTE_PACK;
      end
      default: begin
        op = SPU_NONE;
      end
    endcase
  end

  // Write only for a true predicate
  assign do_write = S_VALID_I && S_COND_I && (op != SPU_NONE);   // [RULE12]

  ////////////////////////////////////////////////////////////////////////////
  // Signed halfword pack
  logic [15:0] half_first;
  logic [15:0] half_second;
  logic        first_above;
  logic        first_below;
  logic        second_above;
  logic        second_below;
  logic [31:0] half_res;

  // Out of range when bits 30:15 disagree with the sign bit
  assign first_above  = !FIRST_OPERAND_I[31] &&
                        (FIRST_OPERAND_I[30:15] != 16'h0000);   // [RULE11]
  assign first_below  = FIRST_OPERAND_I[31] &&
                        (FIRST_OPERAND_I[30:15] != 16'hFFFF);   // [RULE11]
  assign second_above = !SECOND_OPERAND_I[31] &&
                        (SECOND_OPERAND_I[30:15] != 16'h0000);  // [RULE11]
  assign second_below = SECOND_OPERAND_I[31] &&
                        (SECOND_OPERAND_I[30:15] != 16'hFFFF);  // [RULE11]

  // Clamp the first operand, bound for the upper half
  always_comb begin
    if (first_above) begin
      half_first = `SPU_HALF_MAX;                               // [RULE11]
    end else if (first_below) begin
      half_first = `SPU_HALF_MIN;                               // [RULE11]
    end else begin
      half_first = FIRST_OPERAND_I[15:0];                       // [RULE11]
    end
  end

  // Clamp the second operand, bound for the lower half
  always_comb begin
    if (second_above) begin
      half_second = `SPU_HALF_MAX;                              // [RULE11]
    end else if (second_below) begin
      half_second = `SPU_HALF_MIN;                              // [RULE11]
    end else begin
      half_second = SECOND_OPERAND_I[15:0];                     // [RULE11]
    end
  end

  // Each operand clamped on its own, then packed
  assign half_res = {half_first, half_second};                  // [RULE10]

  ////////////////////////////////////////////////////////////////////////////
  // Unsigned byte pack, one clamp per field
  logic [31:0] byte_res;
  logic [63:0] halves;
  assign halves = {FIRST_OPERAND_I, SECOND_OPERAND_I};          // [RULE4]

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_clamp
      spu_byte_clamp u_clamp (
        .half_i (halves[16*g +: 16]),
        .byte_o (byte_res[8*g +: 8])
      );                                                        // [RULE3]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write-back at end of the first execute stage
  logic [31:0] next_result;

  // Pick the pack result; a refused slot keeps the old value
  always_comb begin
    unique case (op)
      SPU_HALF_PACK: begin
        next_result = half_res;
      end
      SPU_BYTE_PACK: begin
        next_result = byte_res;
      end
      SPU_NONE: begin
        next_result = S_RESULT_O;
      end
    endcase
  end

  // Write strobe, one cycle per accepted pack
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      S_WE_O <= 1'b0;
    end else if (CE_I) begin
      S_WE_O <= do_write;                                       // [RULE1] [RULE12]
    end
  end

  // Executing unit of the last written pack
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      S_UNIT_O <= 1'b0;
    end else if (CE_I && do_write) begin
      S_UNIT_O <= S_UNIT_I;                                     // [RULE2]
    end
  end

  // Destination register number
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      S_DST_O <= `SPU_REGNUM_RST;
    end else if (CE_I && do_write) begin
      S_DST_O <= S_DST_I;                                       // [RULE12]
    end
  end

  // Cross-path flag of the second operand
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      S_CROSS_O <= 1'b0;
    end else if (CE_I && do_write) begin
      S_CROSS_O <= S_CROSS_I;                                   // [RULE2]
    end
  end

  // Result word, unchanged under a false predicate
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      S_RESULT_O <= `SPU_RESULT_RST;
    end else if (CE_I && do_write) begin
      S_RESULT_O <= next_result;                                // [RULE1] [RULE12]
    end
  end

  // Packs never touch the saturation flag
  assign SAT_SET_O = 1'b0;                                      // [RULE8] [RULE11]

  ////////////////////////////////////////////////////////////////////////////
  // Shift decode on the M units
  logic shift_hit;

  // Operation field match with a true predicate
  assign shift_hit = M_VALID_I && M_COND_I &&
                     (M_OPFIELD_I == `SPU_OP_M_SHIFT_LEFT);     // [RULE9]

  // Decode strobe, one cycle per accepted shift
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      SHIFT_DEC_O <= 1'b0;
    end else if (CE_I) begin
      SHIFT_DEC_O <= shift_hit;                                 // [RULE9]
    end
  end

  // Multiply unit of the M slot, registered every enabled cycle, shift or not
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      SHIFT_UNIT_O <= 1'b0;
    end else if (CE_I) begin
      SHIFT_UNIT_O <= M_UNIT_I;                                 // [RULE9]
    end
  end
endmodule
`default_nettype wire

/* File: spu_pack_unit_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module spu_pack_chk (
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic        CE_I,
  input wire logic        S_VALID_I,
  input wire logic [3:0]  S_OPFIELD_I,
  input wire logic        S_COND_I,
  input wire logic [31:0] FIRST_OPERAND_I,
  input wire logic        M_VALID_I,
  input wire logic [4:0]  M_OPFIELD_I,
  input wire logic        M_COND_I,
  input wire logic        S_WE_O,
  input wire logic [31:0] S_RESULT_O,
  input wire logic        SAT_SET_O,
  input wire logic        SHIFT_DEC_O
);
  // Accepted operations of each kind
  wire hp = CE_I && S_VALID_I && S_COND_I && S_OPFIELD_I == 4'h2;
  wire bp = CE_I && S_VALID_I && S_COND_I && S_OPFIELD_I == 4'h4;
  wire sh = CE_I && M_VALID_I && M_COND_I && M_OPFIELD_I == 5'h1C;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  chk_we_pulse: assert property (hp || bp |=> S_WE_O) else $error("pack not written");
  chk_false_pred: assert property (CE_I && S_VALID_I && !S_COND_I |=> !S_WE_O) else $error("false write");
  chk_hold_res: assert property (!S_WE_O |-> $stable(S_RESULT_O)) else $error("result moved");
  chk_sat_quiet: assert property (!SAT_SET_O) else $error("saturation flag set");
  chk_shift_dec: assert property (sh |=> SHIFT_DEC_O) else $error("shift not decoded");
  chk_byte_top: assert property (bp && !FIRST_OPERAND_I[31] && |FIRST_OPERAND_I[30:24]
    |=> S_RESULT_O[31:24] == 8'hFF) else $error("byte not clamped high");
  chk_byte_neg: assert property (bp && FIRST_OPERAND_I[15]
    |=> S_RESULT_O[23:16] == 8'h00) else $error("byte not clamped low");
  chk_half_pos: assert property (hp && !FIRST_OPERAND_I[31] && |FIRST_OPERAND_I[30:15]
    |=> S_RESULT_O[31:16] == 16'h7FFF) else $error("half not clamped");
  cover property (hp);
  cover property (bp);
  cover property (sh);
endmodule
bind spu_pack_unit spu_pack_chk u_chk (.*);
`default_nettype wire

/* File: spu_params.svh */
`ifndef SPU_PARAMS_SVH
`define SPU_PARAMS_SVH
// Contract
// [RULE1] Both packs read their operands and write the result in the first execute stage, single cycle, no delay slots.
// [RULE2] The unsigned byte pack runs on either of the two S-side units, with a cross-path-capable second operand.
// [RULE3] The unsigned byte pack treats each source as two signed halfwords and clamps each of the four alone to an unsigned byte.
// [RULE4] Byte order: first operand high half to 31:24, low half to 23:16, second operand high half to 15:8, low half to 7:0.
// [RULE5] A halfword from 0 to 255 passes through as its low eight bits.
// [RULE6] A halfword above 255 gives 255.
// [RULE7] A negative halfword gives zero.
// [RULE8] The unsigned byte pack never changes the saturation flag.
// [RULE9] The variable saturating left shift decodes on either multiply unit with operation field 11100.
// [RULE10] The signed halfword pack clamps each 32-bit source alone, first operand to the upper half, second to the lower.
// [RULE11] Halfword pack gives 0x7FFF above range, 0x8000 below, truncates in range, and leaves the saturation flag alone.
// [RULE12] A false predicate performs no operation and leaves the destination unchanged.

// Operation field codes on the S units (4 bits)
`define SPU_OP_S_HALF_PACK   4'h2
`define SPU_OP_S_BYTE_PACK   4'h4
// Operation field code on the M units (5 bits)
`define SPU_OP_M_SHIFT_LEFT  5'h1C
// Clamp limits
`define SPU_HALF_MAX         16'h7FFF
`define SPU_HALF_MIN         16'h8000
`define SPU_BYTE_MAX         8'hFF
`define SPU_BYTE_MIN         8'h00
// Reset values
`define SPU_RESULT_RST       32'h0000_0000
`define SPU_REGNUM_RST       5'h00
`endif

/* File: spu_pkg.sv */
package spu_pkg;
  typedef enum logic [1:0] {
    SPU_NONE,
    SPU_HALF_PACK,
    SPU_BYTE_PACK
  } spu_op_t;
endpackage

/* File: spu_rf_model.sv */
`timescale 1ns/1ns
`default_nettype none
module spu_rf_model (
  input wire logic        clk_i,
  input wire logic        we_i,
  input wire logic [4:0]  dst_i,
  input wire logic [31:0] data_i
);
  logic [31:0] regs [32];
  // Destination write-back
  always_ff @(posedge clk_i) if (we_i) regs[dst_i] <= data_i;
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        CLK_I = 0, SRST_I = 1, CE_I = 1, S_VALID_I = 0, S_UNIT_I = 0, S_COND_I = 0;
  logic        S_CROSS_I = 0, M_VALID_I = 0, M_UNIT_I = 0, M_COND_I = 0;
  logic [3:0]  S_OPFIELD_I = 0;
  logic [4:0]  S_DST_I = 0, M_OPFIELD_I = 0, S_DST_O;
  logic [31:0] FIRST_OPERAND_I = 0, SECOND_OPERAND_I = 0, S_RESULT_O;
  logic        S_WE_O, S_UNIT_O, S_CROSS_O, SAT_SET_O, SHIFT_DEC_O, SHIFT_UNIT_O;
  int          mismatches = 0, comparisons = 0;
  always #2 CLK_I = ~CLK_I;
  spu_pack_unit uut (.*);
  spu_rf_model rf (.clk_i(CLK_I), .we_i(S_WE_O), .dst_i(S_DST_O), .data_i(S_RESULT_O));
  task automatic close_out;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One instruction on both units; opfield also picks the destination
  task automatic op(input logic [3:0] f, input logic c, u, input logic [31:0] a, b);
    @(posedge CLK_I);
    {S_VALID_I, M_VALID_I, S_COND_I, M_COND_I, S_UNIT_I, M_UNIT_I} <= {2'h3, c, c, u, u};
    {S_OPFIELD_I, M_OPFIELD_I, S_DST_I} <= {f, 1'b1, f, u, f};
    FIRST_OPERAND_I <= a;
    SECOND_OPERAND_I <= b;
    @(posedge CLK_I);
    {S_VALID_I, M_VALID_I} <= 2'h0;
    #1;
  endtask
  task automatic t_half;
    op(4'h2, 1, 0, 32'h3789_F23A, 32'h04B8_4975);
    chk(S_RESULT_O, 32'h7FFF_7FFF);
    op(4'h2, 1, 1, 32'hA124_2451, 32'h01A6_A051);
    chk(S_RESULT_O, 32'h8000_7FFF);
    chk({S_WE_O, S_UNIT_O, S_DST_O}, 7'h72);
    op(4'h2, 1, 0, 32'hFFFF_FFFE, 32'h0000_0005);
    chk(S_RESULT_O, 32'hFFFE_0005);
  endtask
  task automatic t_byte;
    op(4'h4, 1, 0, 32'h3789_F23A, 32'h04B8_4975);
    chk(S_RESULT_O, 32'hFF00_FFFF);
    op(4'h4, 1, 1, 32'hA124_2451, 32'h01A6_A051);
    chk(S_RESULT_O, 32'h00FF_FF00);
    op(4'h4, 1, 0, 32'h00FF_0100, 32'h0000_0080);
    chk(S_RESULT_O, 32'hFFFF_0080);
    chk(SAT_SET_O, 0);
  endtask
  // False predicate leaves the written register alone
  task automatic t_refuse;
    op(4'h4, 0, 0, 32'hFFFF_FFFF, 32'h0000_0000);
    chk({S_WE_O, S_RESULT_O}, 33'h0_FFFF_0080);
    chk(rf.regs[5'h04], 32'hFFFF_0080);
  endtask
  task automatic t_shift;
    op(4'hC, 1, 1, 32'h0000_0000, 32'h0000_0000);
    chk({SHIFT_DEC_O, SHIFT_UNIT_O, S_WE_O}, 3'h6);
    op(4'hD, 1, 0, 32'h0000_0000, 32'h0000_0000);
    chk({SHIFT_DEC_O, S_WE_O}, 2'h0);
  endtask
  // Enable low freezes state, then a cross-path pack, then a mid-run reset
  task automatic t_freeze;
    @(posedge CLK_I);
    CE_I <= 0;
    {S_VALID_I, S_COND_I, S_OPFIELD_I, S_DST_I, S_CROSS_I} <= {2'h3, 4'h2, 5'h09, 1'b1};
    @(posedge CLK_I);
    {CE_I, S_VALID_I} <= 2'h2;
    #1;
    chk({S_WE_O, S_RESULT_O}, 33'h0_FFFF_0080);
    chk(S_DST_O, 5'h04);
    op(4'h2, 1, 0, 32'h0000_1234, 32'hFFFF_0000);
    chk(S_RESULT_O, 32'h1234_8000);
    chk({S_WE_O, S_CROSS_O, S_DST_O}, 7'h62);
    @(posedge CLK_I);
    SRST_I <= 1;
    @(posedge CLK_I);
    SRST_I <= 0;
    #1;
    chk(S_RESULT_O, 32'h0000_0000);
    chk({S_WE_O, S_CROSS_O, S_UNIT_O, S_DST_O, SHIFT_DEC_O}, 9'h000);
  endtask
  initial begin
    repeat (16) @(posedge CLK_I);
    SRST_I <= 0;
    t_half;
    t_byte;
    t_refuse;
    t_shift;
    t_freeze;
    close_out;
  end
endmodule
`default_nettype wire
